/* verilog/cmb_defs.vh */
// Constants for the CAN message buffer block
`ifndef CMB_DEFS_VH
`define CMB_DEFS_VH

// ************************************************************
// Byte slots inside one 16-byte message buffer
// ************************************************************
`define CMB_SLOT_ID0 4'h0
`define CMB_SLOT_ID1 4'h1
`define CMB_SLOT_ID2 4'h2
`define CMB_SLOT_ID3 4'h3
`define CMB_SLOT_DATA0 4'h4
`define CMB_SLOT_DLC 4'hc
`define CMB_SLOT_LOCAL_PRIORITY_FIELD 4'hd
`define CMB_SLOT_TSH 4'he
`define CMB_SLOT_TSL 4'hf

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define CMB_WIN_RX 2'h0
`define CMB_WIN_TX 2'h1
`define CMB_IDX_CTRL 6'h20
`define CMB_IDX_TXFLG 6'h21
`define CMB_IDX_TBSEL 6'h22
`define CMB_IDX_RXFLG 6'h23
`define CMB_IDX_STATUS 6'h24
`define CMB_IDX_STAMP 6'h25

// ************************************************************
// Field positions and reset values
// ************************************************************
`define CMB_CTRL_INIT 0
`define CMB_CTRL_STAMP 1
`define CMB_CTRL_RESET 2'h1
`define CMB_TXE_RESET 3'h7
`define CMB_EXT_SRR 4
`define CMB_IDE_BIT 3
`define CMB_EXT_RTR 0
`define CMB_STD_RTR 4
`define CMB_MAX_BYTES 4'h8

`endif

/* verilog/cmb_local_priority_field_sel.v */
// Local-priority selection among scheduled transmit buffers
`timescale 1ns/10ps
module cmb_local_priority_field_sel #(
  parameter NBUF = 3,
  parameter IW = 2
)(
  input wire [NBUF-1:0] ready,
  input wire [8*NBUF-1:0] local_priority_field_flat,
  output reg [IW-1:0] win_idx,
  output reg win_valid
);
  integer k;
  reg [7:0] best;

  // ************************************************************
  // Lowest value wins, strict compare keeps the lower index on ties
  // ************************************************************
  always @*
  begin
    win_valid = 1'b0;
    win_idx = {IW{1'b0}};
    best = 8'hff;
    for (k = 0; k < NBUF; k = k + 1)
    begin
      if (ready[k] && (!win_valid || local_priority_field_flat[8*k +: 8] < best))
      begin
        win_valid = 1'b1;
        win_idx = k[IW-1:0];
        best = local_priority_field_flat[8*k +: 8];
      end
    end
  end
endmodule

/* verilog/cmb_stamp_cnt.v */
// Free-running bit-time counter used for message stamps
`timescale 1ns/10ps
module cmb_stamp_cnt #(
  parameter W = 16
)(
  input wire clk,
  input wire nrst,
  input wire init_mode,
  input wire bit_tick,
  output reg [W-1:0] cnt_q
);
  // ************************************************************
  // Counter: cleared in init mode, wraps silently, no overflow flag
  // ************************************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= {W{1'b0}};
    else if (init_mode)
      cnt_q <= {W{1'b0}};
    else if (bit_tick)
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
  end
endmodule

/* verilog/cmb_top.v */
// CAN message buffers with APB access, local priority and stamping
// How it works
// - Extended format keeps a 29-bit identifier, top bit sent first.
// - Extended: fourth id byte bits 7..1 hold identifier bits 6..0.
// - Smaller identifier value means higher bus priority.
// - Extended: fourth id byte bit 0 is the remote flag.
// - Standard: 11-bit id, upper eight in byte one, lower three in byte two.
// - Standard: remote flag bit 4, extension flag bit 3 of byte two.
// - Extension flag stored on receive, selects id type on transmit.
// - Standard mapping leaves the third id byte unused and undefined.
// - Eight data bytes per buffer, length code picks how many move.
// - Four-bit length code is a plain binary count, zero to eight.
// - Remote frames send the length code but no data bytes.
// - Every scheduled buffer joins selection just before start of frame.
// - Lowest local priority wins, lower index breaks ties.
// - With stamping on, counter is written after a valid frame ends.
// - Stamp counter runs per bit, no overflow, cleared in init mode.
// - Stamps are read-only; transmit stamps read after empty flag.
// - Each transmit buffer holds an 8-bit local priority.
// - Each buffer keeps a 16-bit stamp as high and low bytes.
`timescale 1ns/10ps
`include "cmb_defs.vh"
module cmb_top #(
  parameter AW = 12,
  parameter NTX = 3,
  parameter SW = 16
)(
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire bit_tick,
  input wire sof_req,
  input wire tx_done,
  input wire tx_lost,
  output wire tx_valid,
  output wire [1:0] tx_buf,
  output wire tx_ide,
  output wire [28:0] tx_id,
  output wire tx_srr,
  output wire tx_rtr,
  output wire [3:0] tx_dlc,
  output wire [3:0] tx_byte_count,
  output wire [63:0] tx_data,
  input wire rx_done,
  input wire rx_ide,
  input wire [28:0] rx_id,
  input wire rx_srr,
  input wire rx_rtr,
  input wire [3:0] rx_dlc,
  input wire [63:0] rx_data,
  output wire rx_dropped
);
  // ************************************************************
  // Helper functions
  // ************************************************************
  // Bytes moved for a length code and frame type
  function [3:0] cmb_count;
    input [3:0] dlc;
    input rtr;
    begin
      if (rtr)
        cmb_count = 4'h0;
      else if (dlc > `CMB_MAX_BYTES)
        cmb_count = `CMB_MAX_BYTES;
      else
        cmb_count = dlc;
    end
  endfunction

  // Register index that answers on the bus
  function cmb_mapped;
    input [5:0] idx;
    begin
      if (idx[5:4] == `CMB_WIN_RX || idx[5:4] == `CMB_WIN_TX)
        cmb_mapped = 1'b1;
      else if (idx >= `CMB_IDX_CTRL && idx <= `CMB_IDX_STAMP)
        cmb_mapped = 1'b1;
      else
        cmb_mapped = 1'b0;
    end
  endfunction

  // Index of the lowest set bit of a 3-bit one-hot value
  function [1:0] cmb_low_idx;
    input [2:0] v;
    begin
      if (v[0])
        cmb_low_idx = 2'h0;
      else if (v[1])
        cmb_low_idx = 2'h1;
      else
        cmb_low_idx = 2'h2;
    end
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  reg [7:0] tx_mem_q [0:4*16-1];
  reg [7:0] rx_mem_q [0:15];
  reg [1:0] ctrl_q;
  reg [2:0] txe_q;
  reg [2:0] txe_d;
  reg [2:0] sel_q;
  reg rxf_q;
  reg rxf_d;
  reg busy_q;
  reg [1:0] cur_q;
  reg [31:0] prdata_q;
  reg pslverr_q;
  reg [7:0] rd_d;
  reg tx_ide_q;
  reg [28:0] tx_id_q;
  reg tx_srr_q;
  reg tx_rtr_q;
  reg [3:0] tx_dlc_q;
  reg [3:0] tx_cnt_q;
  reg [63:0] tx_data_q;
  reg [63:0] tx_data_d;
  reg drop_q;
  reg [3:0] j;
  reg [3:0] k_rx;
  wire [SW-1:0] stamp;
  wire [1:0] win_idx;
  wire win_valid;
  wire [23:0] local_priority_field_flat;
  wire [5:0] idx;
  wire [3:0] slot;
  wire [1:0] sel_idx;
  wire tx_win_ok;
  wire wr_en;
  wire init_mode;
  wire stamp_en;
  wire tx_fin;
  wire rx_take;
  wire [3:0] rx_cnt;
  wire [7:0] w0, w1, w2, w3;
  wire [7:0] r1_d;
  wire w_ide;
  wire [3:0] w_dlc;
  wire [3:0] w_cnt;

  assign idx = paddr[7:2];
  assign slot = idx[3:0];
  assign sel_idx = cmb_low_idx(sel_q);
  assign init_mode = ctrl_q[`CMB_CTRL_INIT];
  assign stamp_en = ctrl_q[`CMB_CTRL_STAMP];
  // Transmit window open only for a selected, empty buffer
  assign tx_win_ok = (sel_q != 3'h0) && txe_q[sel_idx];
  assign wr_en = psel && penable && pwrite && !pslverr_q;
  assign tx_fin = tx_done && busy_q;
  assign rx_take = rx_done && !rxf_q;
  assign rx_cnt = cmb_count(rx_dlc, rx_rtr);

  // ************************************************************
  // Submodules
  // ************************************************************
  assign local_priority_field_flat = {tx_mem_q[{2'h2, `CMB_SLOT_LOCAL_PRIORITY_FIELD}], tx_mem_q[{2'h1, `CMB_SLOT_LOCAL_PRIORITY_FIELD}],
                      tx_mem_q[{2'h0, `CMB_SLOT_LOCAL_PRIORITY_FIELD}]};

  cmb_local_priority_field_sel #(.NBUF(NTX), .IW(2)) u_local_priority_field (
    .ready(~txe_q),
    .local_priority_field_flat(local_priority_field_flat),
    .win_idx(win_idx),
    .win_valid(win_valid)
  );

  cmb_stamp_cnt #(.W(SW)) u_cnt (
    .clk(clk),
    .nrst(nrst),
    .init_mode(init_mode),
    .bit_tick(bit_tick),
    .cnt_q(stamp)
  );

  // ************************************************************
  // APB read decode
  // ************************************************************
  always @*
  begin
    rd_d = 8'h00;
    if (idx[5:4] == `CMB_WIN_RX)
    begin
      if (rxf_q)
        rd_d = rx_mem_q[slot];
    end
    else if (idx[5:4] == `CMB_WIN_TX)
    begin
      if (tx_win_ok)
        rd_d = tx_mem_q[{sel_idx, slot}];
    end
    else if (idx == `CMB_IDX_CTRL)
      rd_d = {6'h00, ctrl_q};
    else if (idx == `CMB_IDX_TXFLG)
      rd_d = {5'h00, txe_q};
    else if (idx == `CMB_IDX_TBSEL)
      rd_d = {5'h00, sel_q};
    else if (idx == `CMB_IDX_RXFLG)
      rd_d = {7'h00, rxf_q};
    else if (idx == `CMB_IDX_STATUS)
      rd_d = {4'h0, win_valid, busy_q, cur_q};
    else
      rd_d = 8'h00;
  end

  // Read data and error latched in the setup cycle
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else if (psel && !penable)
    begin
      if (idx == `CMB_IDX_STAMP)
        prdata_q <= {{(32-SW){1'b0}}, stamp};
      else
        prdata_q <= {24'h000000, rd_d};
      pslverr_q <= !(cmb_mapped(idx) && paddr[AW-1:8] == {(AW-8){1'b0}}
                     && paddr[1:0] == 2'h0);
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q;

  // ************************************************************
  // Control, select and flag registers
  // ************************************************************
  always @*
  begin
    txe_d = txe_q;
    if (wr_en && idx == `CMB_IDX_TXFLG)
      txe_d = txe_d & ~pwdata[2:0];
    if (tx_fin)
      txe_d[cur_q] = 1'b1; // Set wins over a same-cycle clear
    rxf_d = rxf_q;
    if (wr_en && idx == `CMB_IDX_RXFLG && pwdata[0])
      rxf_d = 1'b0;
    if (rx_take)
      rxf_d = 1'b1;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= `CMB_CTRL_RESET;
      txe_q <= `CMB_TXE_RESET;
      sel_q <= 3'h0;
      rxf_q <= 1'b0;
      drop_q <= 1'b0;
    end
    else
    begin
      txe_q <= txe_d;
      rxf_q <= rxf_d;
      drop_q <= rx_done && rxf_q;
      if (wr_en && idx == `CMB_IDX_CTRL)
        ctrl_q <= pwdata[1:0];
      // Keep only the lowest requested buffer that is empty
      if (wr_en && idx == `CMB_IDX_TBSEL)
      begin
        if (pwdata[0] && txe_q[0])
          sel_q <= 3'h1;
        else if (pwdata[1] && txe_q[1])
          sel_q <= 3'h2;
        else if (pwdata[2] && txe_q[2])
          sel_q <= 3'h4;
        else
          sel_q <= 3'h0;
      end
    end
  end

  assign rx_dropped = drop_q;

  // ************************************************************
  // Transmit buffer storage
  // ************************************************************
  always @(posedge clk)
  begin
    if (wr_en && idx[5:4] == `CMB_WIN_TX && tx_win_ok
        && slot != `CMB_SLOT_TSH && slot != `CMB_SLOT_TSL)
      tx_mem_q[{sel_idx, slot}] <= pwdata[7:0];
    if (tx_fin && stamp_en)
    begin
      tx_mem_q[{cur_q, `CMB_SLOT_TSH}] <= stamp[15:8];
      tx_mem_q[{cur_q, `CMB_SLOT_TSL}] <= stamp[7:0];
    end
  end

  // ************************************************************
  // Unpack winner for the protocol engine
  // ************************************************************
  assign w0 = tx_mem_q[{win_idx, `CMB_SLOT_ID0}];
  assign w1 = tx_mem_q[{win_idx, `CMB_SLOT_ID1}];
  assign w2 = tx_mem_q[{win_idx, `CMB_SLOT_ID2}];
  assign w3 = tx_mem_q[{win_idx, `CMB_SLOT_ID3}];
  assign w_ide = w1[`CMB_IDE_BIT];
  assign w_dlc = tx_mem_q[{win_idx, `CMB_SLOT_DLC}][3:0];
  assign w_cnt = cmb_count(w_dlc, w_ide ? w3[`CMB_EXT_RTR] : w1[`CMB_STD_RTR]);

  // Only the counted bytes are presented, rest zero
  always @*
  begin
    tx_data_d = 64'h0;
    for (j = 4'h0; j < `CMB_MAX_BYTES; j = j + 4'h1)
    begin
      if (j < w_cnt)
        tx_data_d[8*j +: 8] = tx_mem_q[{win_idx, `CMB_SLOT_DATA0 + j}];
    end
  end

  // Capture winner at start of frame; free on finish or loss
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_q <= 1'b0;
      cur_q <= 2'h0;
      tx_ide_q <= 1'b0;
      tx_id_q <= 29'h0;
      tx_srr_q <= 1'b0;
      tx_rtr_q <= 1'b0;
      tx_dlc_q <= 4'h0;
      tx_cnt_q <= 4'h0;
      tx_data_q <= 64'h0;
    end
    else if (busy_q)
    begin
      if (tx_done || tx_lost)
        busy_q <= 1'b0;
    end
    else if (sof_req && win_valid && !init_mode)
    begin
      busy_q <= 1'b1;
      cur_q <= win_idx;
      tx_ide_q <= w_ide;
      if (w_ide)
      begin
        // Extended: id28 at the top so it leaves first
        tx_id_q <= {w0, w1[7:5], w1[2:0], w2, w3[7:1]};
        tx_rtr_q <= w3[`CMB_EXT_RTR];
        tx_srr_q <= w1[`CMB_EXT_SRR];
      end
      else
      begin
        tx_id_q <= {18'h0, w0, w1[7:5]};
        tx_rtr_q <= w1[`CMB_STD_RTR];
        tx_srr_q <= 1'b0;
      end
      tx_dlc_q <= w_dlc;
      tx_cnt_q <= w_cnt;
      tx_data_q <= tx_data_d;
    end
  end

  assign tx_valid = busy_q;
  assign tx_buf = cur_q;
  assign tx_ide = tx_ide_q;
  assign tx_id = tx_id_q;
  assign tx_srr = tx_srr_q;
  assign tx_rtr = tx_rtr_q;
  assign tx_dlc = tx_dlc_q;
  assign tx_byte_count = tx_cnt_q;
  assign tx_data = tx_data_q;

  // ************************************************************
  // Receive buffer storage
  // ************************************************************
  assign r1_d = rx_ide ? {rx_id[20:18], rx_srr, 1'b1, rx_id[17:15]}
                       : {rx_id[2:0], rx_rtr, 1'b0, 3'h0};

  always @(posedge clk)
  begin
    if (rx_take)
    begin
      if (rx_ide)
      begin
        rx_mem_q[`CMB_SLOT_ID0] <= rx_id[28:21];
        rx_mem_q[`CMB_SLOT_ID2] <= rx_id[14:7];
        rx_mem_q[`CMB_SLOT_ID3] <= {rx_id[6:0], rx_rtr};
      end
      else
        rx_mem_q[`CMB_SLOT_ID0] <= rx_id[10:3];
      rx_mem_q[`CMB_SLOT_ID1] <= r1_d;
      rx_mem_q[`CMB_SLOT_DLC] <= {4'h0, rx_dlc};
      for (k_rx = 4'h0; k_rx < `CMB_MAX_BYTES; k_rx = k_rx + 4'h1)
      begin
        if (k_rx < rx_cnt)
          rx_mem_q[`CMB_SLOT_DATA0 + k_rx] <= rx_data[8*k_rx +: 8];
      end
      if (stamp_en)
      begin
        rx_mem_q[`CMB_SLOT_TSH] <= stamp[15:8];
        rx_mem_q[`CMB_SLOT_TSL] <= stamp[7:0];
      end
    end
  end
endmodule

/* verification/cmb_chk.sv */
// Port checker for the CAN message buffer top
`timescale 1ns/10ps
module cmb_chk #(
  parameter AW = 12
)(
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire [AW-1:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire sof_req,
  input wire tx_done,
  input wire tx_lost,
  input wire tx_valid,
  input wire tx_ide,
  input wire tx_rtr,
  input wire [28:0] tx_id,
  input wire [1:0] tx_buf,
  input wire [3:0] tx_dlc,
  input wire [3:0] tx_byte_count,
  input wire [63:0] tx_data,
  input wire rx_done,
  input wire rx_dropped
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Setup cycle outside the register map
  wire adr_bad = (paddr[7:2] > 6'h25) || (paddr[1:0] != 2'h0) || ((paddr >> 8) != 0);
  sequence s_busy;
    tx_valid && !tx_done && !tx_lost;
  endsequence
  sequence s_end;
    tx_valid && (tx_done || tx_lost);
  endsequence
  start_sof_a: assert property ($rose(tx_valid) |-> $past(sof_req))
    else $error("capture without start of frame");
  frame_hold_a: assert property (s_busy |=> tx_valid && $stable(tx_id)
    && $stable(tx_buf) && $stable(tx_dlc))
    else $error("captured frame changed");
  frame_end_a: assert property (s_end |=> !tx_valid)
    else $error("capture not released");
  remote_nodata_a: assert property (tx_valid && tx_rtr |-> tx_byte_count == 4'h0)
    else $error("remote frame with data bytes");
  byte_count_a: assert property (tx_valid && !tx_rtr |->
    tx_byte_count == ((tx_dlc > 4'h8) ? 4'h8 : tx_dlc))
    else $error("byte count wrong");
  data_tail_a: assert property (tx_valid |-> (tx_data >> {tx_byte_count, 3'h0}) == 64'h0)
    else $error("bytes beyond count");
  std_upper_a: assert property (tx_valid && !tx_ide |-> tx_id[28:11] == 18'h0)
    else $error("standard id too wide");
  drop_cause_a: assert property (rx_dropped |-> $past(rx_done))
    else $error("drop without frame");
  bad_addr_a: assert property (psel && !penable && adr_bad |=> pslverr)
    else $error("unmapped access accepted");
  good_addr_a: assert property (psel && !penable && !adr_bad |=> !pslverr && pready)
    else $error("mapped access refused");
endmodule
bind cmb_top cmb_chk #(.AW(AW)) u_chk (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .sof_req(sof_req),
  .tx_done(tx_done), .tx_lost(tx_lost), .tx_valid(tx_valid), .tx_ide(tx_ide),
  .tx_rtr(tx_rtr), .tx_id(tx_id), .tx_buf(tx_buf), .tx_dlc(tx_dlc),
  .tx_byte_count(tx_byte_count), .tx_data(tx_data), .rx_done(rx_done),
  .rx_dropped(rx_dropped));

/* verification/cmb_peer.sv */
// Behavioural CAN engine and bus model at the far side
`timescale 1ns/10ps
module cmb_peer (
  input wire clk,
  output logic bit_tick,
  output logic sof_req,
  output logic tx_done,
  output logic tx_lost,
  output logic rx_done,
  output logic rx_ide,
  output logic [28:0] rx_id,
  output logic rx_srr,
  output logic rx_rtr,
  output logic [3:0] rx_dlc,
  output logic [63:0] rx_data
);
  // Idle levels
  initial
  begin
    {bit_tick, sof_req, tx_done, tx_lost, rx_done} = 5'h00;
    {rx_ide, rx_id, rx_srr, rx_rtr, rx_dlc, rx_data} = '0;
  end
  // Bit times, one pulse per two clocks
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk) bit_tick <= 1'b1;
      @(posedge clk) bit_tick <= 1'b0;
    end
  endtask
  // Engine about to send start of frame
  task automatic sof();
    @(posedge clk) sof_req <= 1'b1;
    @(posedge clk) sof_req <= 1'b0;
  endtask
  // Frame end after a delay: valid end or lost arbitration
  task automatic fin(input bit ok, input int dly);
    repeat (dly) @(posedge clk);
    @(posedge clk);
    tx_done <= ok;
    tx_lost <= !ok;
    @(posedge clk);
    tx_done <= 1'b0;
    tx_lost <= 1'b0;
  endtask
  // Valid received frame, fields scrambled once released
  task automatic rx(input bit ide, input [28:0] id, input bit rtr, input [3:0] dlc,
                    input [63:0] d);
    @(posedge clk);
    rx_done <= 1'b1;
    {rx_ide, rx_id, rx_srr, rx_rtr, rx_dlc, rx_data} <= {ide, id, ide, rtr, dlc, d};
    @(posedge clk);
    rx_done <= 1'b0;
    {rx_ide, rx_id, rx_srr, rx_rtr, rx_dlc, rx_data} <= ~{ide, id, ide, rtr, dlc, d};
  endtask
endmodule

/* verification/test_can_message_buffer_layout.sv */
// Register-level tests of the CAN message buffer block
`timescale 1ns/10ps
module test_can_message_buffer_layout;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rdv, v;
  logic err;
  wire [31:0] prdata;
  wire pready, pslverr, bit_tick, sof_req, tx_done, tx_lost, rx_done, rx_ide, rx_srr, rx_rtr;
  wire tx_valid, tx_ide, tx_srr, tx_rtr, rx_dropped;
  wire [1:0] tx_buf;
  wire [28:0] tx_id, rx_id;
  wire [3:0] tx_dlc, tx_byte_count, rx_dlc;
  wire [63:0] tx_data, rx_data;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  // ****
  // Harness
  // ****
  always #10 clk = ~clk;
  cmb_top dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_tick(bit_tick), .sof_req(sof_req), .tx_done(tx_done), .tx_lost(tx_lost),
    .tx_valid(tx_valid), .tx_buf(tx_buf), .tx_ide(tx_ide), .tx_id(tx_id), .tx_srr(tx_srr),
    .tx_rtr(tx_rtr), .tx_dlc(tx_dlc), .tx_byte_count(tx_byte_count), .tx_data(tx_data),
    .rx_done(rx_done), .rx_ide(rx_ide), .rx_id(rx_id), .rx_srr(rx_srr), .rx_rtr(rx_rtr),
    .rx_dlc(rx_dlc), .rx_data(rx_data), .rx_dropped(rx_dropped));
  cmb_peer peer (.clk(clk), .bit_tick(bit_tick), .sof_req(sof_req), .tx_done(tx_done),
    .tx_lost(tx_lost), .rx_done(rx_done), .rx_ide(rx_ide), .rx_id(rx_id), .rx_srr(rx_srr),
    .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data));
  // Compare and count
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input bit w, input [5:0] idx, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {4'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input [5:0] idx, input [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk($sformatf("reg %h", idx), rdv, exp);
  endtask
  task automatic wr(input [5:0] idx, input [31:0] d);
    apb(1'b1, idx, d);
  endtask
  // Identifier bytes, first byte on top
  function automatic logic [31:0] idb(input bit ext, input [28:0] id, input bit rtr);
    if (ext)
      return {id[28:21], id[20:18], 2'h3, id[17:15], id[14:7], id[6:0], rtr};
    return {id[10:3], id[2:0], rtr, 4'h0, 16'h0};
  endfunction
  // Fill the selected transmit buffer, stamp write must be ignored
  task automatic load(input int b, input bit ext, input [28:0] id, input bit rtr,
                      input [3:0] dlc, input [7:0] pr);
    v = idb(ext, id, rtr);
    wr(6'h22, 32'h1 << b);
    for (int k = 0; k < 4; k++)
      wr(6'(16 + k), 32'(v[31-8*k -: 8]));
    for (int k = 0; k < 8; k++)
      wr(6'(20 + k), 32'(8'(16 * b + k + 1)));
    wr(6'h1c, 32'(dlc));
    wr(6'h1d, 32'(pr));
    wr(6'h1e, 32'hff);
    rd(6'h1c, 32'(dlc));
    rd(6'h1d, 32'(pr));
  endtask
  // One transmission, optionally after a lost arbitration
  task automatic xmit(input int b, input bit ext, input [28:0] id, input bit rtr,
                      input [3:0] dlc, input bit lose);
    logic [63:0] d;
    int cnt;
    cnt = rtr ? 0 : (dlc > 8 ? 8 : dlc);
    d = '0;
    for (int k = 0; k < cnt; k++)
      d[8*k +: 8] = 8'(16 * b + k + 1);
    if (lose)
    begin
      peer.sof();
      peer.fin(1'b0, 3);
      @(negedge clk);
      chk("lost", tx_valid, 0);
    end
    peer.sof();
    @(negedge clk);
    chk("tx_buf", tx_buf, b);
    chk("tx_id", tx_id, ext ? id : id[10:0]);
    chk("tx_ide", tx_ide, ext);
    chk("tx_srr", tx_srr, ext);
    chk("tx_rtr", tx_rtr, rtr);
    chk("tx_dlc", tx_dlc, dlc);
    chk("tx_cnt", tx_byte_count, cnt);
    chk("tx_data", tx_data, d);
    peer.fin(1'b1, 2);
    @(negedge clk);
    chk("tx_end", tx_valid, 0);
  endtask
  task automatic conclude();
    $display("counts: %0d compared, %0d mismatched", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(6'h20, 32'h1);
    rd(6'h21, 32'h7);
    rd(6'h22, 32'h0);
    rd(6'h23, 32'h0);
    rd(6'h25, 32'h0);
    wr(6'h30, 32'h1);
    chk("slverr", err, 1);
    $display("test reset done");
    wr(6'h20, 32'h2);
    peer.ticks(5);
    rd(6'h25, 32'h5);
    load(0, 0, 29'h123, 0, 4'h2, 8'h05);
    load(1, 1, 29'h1abcdef5, 0, 4'ha, 8'h03);
    load(2, 0, 29'h0f0, 1, 4'h5, 8'h03);
    wr(6'h21, 32'h7);
    rd(6'h21, 32'h0);
    wr(6'h22, 32'h1);
    rd(6'h22, 32'h0);
    rd(6'h10, 32'h0);
    xmit(1, 1, 29'h1abcdef5, 0, 4'ha, 1);
    xmit(2, 0, 29'h0f0, 1, 4'h5, 0);
    rd(6'h21, 32'h6);
    wr(6'h22, 32'h7);
    rd(6'h22, 32'h2);
    rd(6'h1e, 32'h0);
    rd(6'h1f, 32'h5);
    wr(6'h1f, 32'h77);
    rd(6'h1f, 32'h5);
    xmit(0, 0, 29'h123, 0, 4'h2, 0);
    $display("test transmit done");
    peer.rx(1, 29'h0abc1234, 0, 4'h3, 64'h0807060504030201);
    rd(6'h23, 32'h1);
    v = idb(1, 29'h0abc1234, 0);
    for (int k = 0; k < 4; k++)
      rd(6'(k), 32'(v[31-8*k -: 8]));
    for (int k = 0; k < 3; k++)
      rd(6'(4 + k), 32'(k + 1));
    rd(6'h0c, 32'h3);
    rd(6'h0f, 32'h5);
    wr(6'h04, 32'h55);
    rd(6'h04, 32'h1);
    peer.rx(0, 29'h7ff, 0, 4'h1, 64'h0);
    @(negedge clk);
    chk("dropped", rx_dropped, 1);
    wr(6'h23, 32'h1);
    rd(6'h23, 32'h0);
    peer.rx(0, 29'h555, 1, 4'h0, 64'h0);
    rd(6'h00, 32'haa);
    rd(6'h01, 32'hb0);
    $display("test receive done");
    wr(6'h20, 32'h1);
    rd(6'h25, 32'h0);
    $display("test init done");
    conclude();
  end
endmodule
